// File: hdl/overlay_pkg.sv
/*
 * constants for the layer overlay compositor: register offset, field
 * positions, reset value, composition method codes, indirect command code.
 * assumes nothing of its surroundings; imported whole by the design files.
 */
package overlay_pkg;

    // ======================================================================
    // register map
    // ======================================================================
    localparam logic [7:0] cfg_offset        = 8'h18;  // overlay setup register
    localparam logic [7:0] cfg_reset         = 8'h00;  // two layers, text, or

    // ======================================================================
    // field positions
    // ======================================================================
    localparam int         layer_count_pos   = 4;      // 1 = three layers
    localparam int         block3_mode_pos   = 3;      // block3_mode_bit
    localparam int         block1_mode_pos   = 2;      // block1_mode_bit
    localparam int         method_lo_pos     = 0;      // compose_method_field lsb
    localparam logic [7:0] cfg_used_mask     = 8'h1f;  // bits 7-5 read as zero

    // ======================================================================
    // indirect command code for layer_setup_command (value arbitrary)
    // ======================================================================
    localparam logic [7:0] layer_setup_code  = 8'h5b;

    // ======================================================================
    // composition methods
    // ======================================================================
    typedef enum logic [1:0] {
        method_or       = 2'b00,
        method_xor      = 2'b01,
        method_and      = 2'b10,
        method_reserved = 2'b11
    } method_t;

    // ======================================================================
    // cursor stepping: moves by memory address, never by glyph width
    // ======================================================================
    localparam logic [3:0] wide_glyph_width  = 4'h9;

endpackage

// File: hdl/pixel_bits_if.sv
/*
 * bundle carrying eight pixels' aligned layer bits and the composed result
 * between the compositor and its mixing stage.
 * assumes one clock; the mixer is purely combinational.
 */
`timescale 1ns/10ps
interface pixel_bits_if;
    logic [7:0] first_bits;    // first_layer byte
    logic [7:0] second_bits;   // second_layer byte
    logic [7:0] third_bits;    // third_layer byte (masked when unused)
    logic [1:0] method;        // compose_method_field
    logic [7:0] mixed;         // composed byte

    modport mixer (input first_bits, second_bits, third_bits, method, output mixed);
    modport owner (output first_bits, second_bits, third_bits, method, input mixed);
endinterface

// File: hdl/layer_mixer.sv
/*
 * per-bit layer mixer: combines three aligned layer bytes by the selected
 * method. assumes the caller masks the third layer when it is not active.
 */
`timescale 1ns/10ps
module layer_mixer
    import overlay_pkg::*;
(
    pixel_bits_if.mixer bits
);

    // ======================================================================
    // mixing
    // ======================================================================
    // each bit mixes on its own, so a byte holds eight independent pixels
    always_comb begin
        case (method_t'(bits.method))
            method_or: begin
                bits.mixed = bits.first_bits | bits.second_bits | bits.third_bits;
            end
            method_xor: begin
                bits.mixed = (bits.first_bits ^ bits.second_bits) | bits.third_bits;
            end
            method_and: begin
                bits.mixed = (bits.first_bits & bits.second_bits) | bits.third_bits;
            end
            default: begin
                // reserved code: blank rather than guess a mix
                bits.mixed = 8'h00;
            end
        endcase
    end

endmodule

// File: hdl/layer_overlay_compositor.sv
/*
 * layer overlay compositor: holds the overlay setup register, reachable
 * by direct register write or by the indirect layer_setup_command with
 * one parameter byte, and composes up to three layer bytes per pixel clock.
 * assumes the fetch logic presents aligned layer bytes with a valid strobe,
 * and the host keeps two layers when text is shown.
 */
`timescale 1ns/10ps

// Contract
// - indirect command parameter loads overlay register
// - layer-count bit selects three or two layers
// - block 3 mode bit: text or graphics
// - block 1 mode bit: text or graphics
// - blocks 2 and 4 always graphics
// - method field: or, xor, and, reserved
// - one method per layer, both blocks
// - second and third layers graphics only
// - cursor steps by address, host presets increment
module layer_overlay_compositor
    import overlay_pkg::*;
(
    input  wire logic       clk,            // pixel clock, 25 MHz
    input  wire logic       rst_n,          // async reset, active low
    input  wire logic       reg_wr,         // direct register write strobe
    input  wire logic       reg_rd,         // direct register read strobe
    input  wire logic [7:0] reg_addr,       // direct register index
    input  wire logic [7:0] reg_wdata,      // direct write data
    input  wire logic       cmd_wr,         // indirect command byte strobe
    input  wire logic       par_wr,         // indirect parameter byte strobe
    input  wire logic [7:0] bus_data,       // indirect command/parameter byte
    input  wire logic       pix_valid,      // layer bytes valid this cycle
    input  wire logic [1:0] pix_block,      // 0..3 = screen block 1..4 of layer 1
    input  wire logic [7:0] first_layer,    // first layer byte
    input  wire logic [7:0] second_layer,   // second layer byte
    input  wire logic [7:0] third_layer,    // third layer byte
    input  wire logic [3:0] glyph_width,    // glyph width minus one field
    input  wire logic [15:0] cursor_addr,   // current cursor address
    input  wire logic [15:0] cursor_step,   // host preset increment
    input  wire logic       cursor_move,    // advance cursor after access
    output logic [7:0]      reg_rdata,      // read data, registered
    output logic            layer_setup_busy, // waiting for parameter byte
    output logic            three_layers,   // three-layer composition active
    output logic            block1_text,    // block 1 shown as text
    output logic            block3_text,    // block 3 shown as text
    output logic [7:0]      panel_data,     // composed byte to panel
    output logic            panel_valid,    // panel_data valid
    output logic            panel_text,     // byte came from a text block
    output logic [15:0]     next_cursor     // cursor after a move
);

    // ======================================================================
    // indirect command decoder state
    // ======================================================================
    typedef enum logic [0:0] {
        idle_st  = 1'b0,    // no command pending
        param_st = 1'b1     // layer_setup_command seen, awaiting byte
    } cmd_state_t;

    cmd_state_t cmd_state;          // current decoder state
    cmd_state_t next_cmd_state;     // decoder next state
    logic [7:0] layer_overlay_config;       // overlay setup register
    logic [7:0] next_layer_overlay_config;  // its next value
    logic [7:0] next_reg_rdata;     // read data next value

    // field decode of the setup register, used in several places
    function automatic logic field_bit(input logic [7:0] cfg, input int pos);
        field_bit = cfg[pos];
    endfunction

    // ======================================================================
    // register write path: direct and indirect
    // ======================================================================
    // a direct write and a parameter byte in the same cycle: the indirect
    // parameter wins, as it completes an already started command
    always_comb begin
        next_cmd_state            = cmd_state;
        next_layer_overlay_config = layer_overlay_config;
        if (reg_wr && reg_addr == cfg_offset) begin
            next_layer_overlay_config = reg_wdata & cfg_used_mask;
        end
        case (cmd_state)
            idle_st: begin
                if (cmd_wr && bus_data == layer_setup_code) begin
                    next_cmd_state = param_st;
                end
            end
            param_st: begin
                if (par_wr) begin
                    // parameter byte goes straight into the register
                    next_layer_overlay_config = bus_data & cfg_used_mask;
                    next_cmd_state            = idle_st;
                end else if (cmd_wr && bus_data != layer_setup_code) begin
                    // another command aborts the pending one
                    next_cmd_state = idle_st;
                end
            end
            default: begin
                next_cmd_state = idle_st;
            end
        endcase
    end

    // register reset to all zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_state            <= idle_st;
            layer_overlay_config <= cfg_reset;
        end else begin
            cmd_state            <= next_cmd_state;
            layer_overlay_config <= next_layer_overlay_config;
        end
    end

    // ======================================================================
    // register read path
    // ======================================================================
    // unmapped indexes read as zero; the port only reaches this one register
    always_comb begin
        next_reg_rdata = reg_rdata;
        if (reg_rd) begin
            next_reg_rdata = (reg_addr == cfg_offset) ? layer_overlay_config : 8'h00;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

    // ======================================================================
    // composition
    // ======================================================================
    pixel_bits_if bits ();          // mixer bundle
    logic       use_third;          // third layer enabled
    logic       text_block;         // current block renders as text
    logic [7:0] next_panel_data;    // panel byte next value
    logic       next_panel_valid;   // panel strobe next value
    logic       next_panel_text;    // text flag next value
    logic       next_three;         // mode flags next values
    logic       next_b1_text;
    logic       next_b3_text;

    // the host keeps two layers with text; hardware only follows the bit
    assign use_third = field_bit(layer_overlay_config, layer_count_pos);

    // only block 1 and 3 take the mode bits; 2 and 4 are bitmaps
    always_comb begin
        case (pix_block)
            2'd0:    text_block = !field_bit(layer_overlay_config, block1_mode_pos);
            2'd2:    text_block = !field_bit(layer_overlay_config, block3_mode_pos);
            default: text_block = 1'b0;
        endcase
    end

    // second and third layers go in raw as bitmaps; the method is taken
    // per layer, never per block
    assign bits.first_bits  = first_layer;
    assign bits.second_bits = second_layer;
    assign bits.third_bits  = use_third ? third_layer : 8'h00;
    assign bits.method      = layer_overlay_config[method_lo_pos +: 2];

    layer_mixer mixer_u (
        .bits (bits.mixer)
    );

    // one register stage: bytes mixed in the cycle they arrive
    always_comb begin
        next_panel_data  = pix_valid ? bits.mixed : 8'h00;
        next_panel_valid = pix_valid;
        next_panel_text  = pix_valid & text_block;
        next_three       = use_third;
        next_b1_text     = !field_bit(layer_overlay_config, block1_mode_pos);
        next_b3_text     = !field_bit(layer_overlay_config, block3_mode_pos);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            panel_data   <= 8'h00;
            panel_valid  <= 1'b0;
            panel_text   <= 1'b0;
            three_layers <= 1'b0;
            block1_text  <= 1'b1;
            block3_text  <= 1'b1;
        end else begin
            panel_data   <= next_panel_data;
            panel_valid  <= next_panel_valid;
            panel_text   <= next_panel_text;
            three_layers <= next_three;
            block1_text  <= next_b1_text;
            block3_text  <= next_b3_text;
        end
    end

    // ======================================================================
    // cursor stepping
    // ======================================================================
    // step is the preset increment whatever the glyph width, so 9-wide
    // glyphs need a host-set step to move by character
    logic [15:0] next_cursor_d;     // next cursor value
    always_comb begin
        next_cursor_d = cursor_move ? 16'(cursor_addr + cursor_step) : next_cursor;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            next_cursor      <= 16'h0000;
            layer_setup_busy <= 1'b0;
        end else begin
            next_cursor      <= next_cursor_d;
            layer_setup_busy <= (next_cmd_state == param_st);
        end
    end

    // ======================================================================
    // checks
    // ======================================================================
    indirect_load_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cmd_state == param_st && par_wr)
        |=> layer_overlay_config == ($past(bus_data) & cfg_used_mask))
        else $error("parameter byte not loaded");
    layer_count_a: assert property (@(posedge clk) disable iff (!rst_n)
        pix_valid && !layer_overlay_config[layer_count_pos]
        && layer_overlay_config[method_lo_pos +: 2] == method_or
        |=> panel_data == ($past(first_layer) | $past(second_layer)))
        else $error("third layer leaked in two-layer mode");
    block3_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
        pix_valid && pix_block == 2'd2
        |=> panel_text == !$past(layer_overlay_config[block3_mode_pos]))
        else $error("block 3 mode wrong");
    block1_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
        pix_valid && pix_block == 2'd0
        |=> panel_text == !$past(layer_overlay_config[block1_mode_pos]))
        else $error("block 1 mode wrong");
    graphics_blocks_a: assert property (@(posedge clk) disable iff (!rst_n)
        pix_valid && pix_block[0] |=> !panel_text)
        else $error("block 2 or 4 shown as text");
    xor_method_a: assert property (@(posedge clk) disable iff (!rst_n)
        pix_valid && layer_overlay_config[layer_count_pos]
        && layer_overlay_config[method_lo_pos +: 2] == method_xor
        |=> panel_data == (($past(first_layer) ^ $past(second_layer)) | $past(third_layer)))
        else $error("xor mix wrong");
    same_method_a: assert property (@(posedge clk) disable iff (!rst_n)
        pix_valid && layer_overlay_config[layer_count_pos]
        && layer_overlay_config[method_lo_pos +: 2] == method_and
        |=> panel_data == (($past(first_layer) & $past(second_layer)) | $past(third_layer)))
        else $error("and mix wrong");
    pixel_timing_a: assert property (@(posedge clk) disable iff (!rst_n)
        pix_valid |=> panel_valid)
        else $error("composed byte late");
    cursor_step_a: assert property (@(posedge clk) disable iff (!rst_n)
        cursor_move && glyph_width == wide_glyph_width
        |=> next_cursor == 16'($past(cursor_addr) + $past(cursor_step)))
        else $error("cursor step wrong");

endmodule

// File: sim/host_model.sv
/* host model: drives the direct register port and the indirect command port.
   assumes one clock; the bench calls its tasks by hierarchical name. */
`timescale 1ns/10ps
module host_model
    import overlay_pkg::*;
(
    input  wire logic       clk,       // pixel clock
    output logic            reg_wr,    // direct write strobe
    output logic            reg_rd,    // direct read strobe
    output logic [7:0]      reg_addr,  // register index
    output logic [7:0]      reg_wdata, // direct write data
    output logic            cmd_wr,    // command byte strobe
    output logic            par_wr,    // parameter byte strobe
    output logic [7:0]      bus_data,  // command or parameter byte
    input  wire logic [7:0] reg_rdata  // read data
);
    // ==========================================================
    // idle levels
    // ==========================================================
    initial begin
        {reg_wr, reg_rd, cmd_wr, par_wr} = 4'h0;
        {reg_addr, reg_wdata, bus_data} = 24'h0;
    end

    // a released byte shows its inverse, so a stale copy never matches
    task automatic release_bus;
        reg_addr  = ~reg_addr;
        reg_wdata = ~reg_wdata;
        bus_data  = ~bus_data;
    endtask

    // one direct write, strobe held across one rising edge
    task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk);
        reg_wr    = 1'b1;
        reg_addr  = addr;
        reg_wdata = data;
        @(negedge clk);
        reg_wr = 1'b0;
        release_bus();
    endtask

    // one direct read; data is registered one edge after the strobe
    task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clk);
        reg_rd   = 1'b1;
        reg_addr = addr;
        @(negedge clk);
        reg_rd = 1'b0;
        data   = reg_rdata;
        release_bus();
    endtask

    // one indirect byte: command when is_par is low, else parameter
    task automatic byte_out(input logic is_par, input logic [7:0] data);
        @(negedge clk);
        cmd_wr   = !is_par;
        par_wr   = is_par;
        bus_data = data;
        @(negedge clk);
        {cmd_wr, par_wr} = 2'b00;
        release_bus();
    endtask

    // overlay setup by either route; a real host never asks for three
    // layers while a text block is shown, so the layer bit is dropped then
    task automatic set_cfg(input logic direct, input logic [7:0] data);
        logic [7:0] safe;
        safe = data;
        if (safe[3:2] != 2'b11) begin
            safe[4] = 1'b0;
        end
        if (direct) begin
            wr_reg(cfg_offset, safe);
        end else begin
            byte_out(1'b0, layer_setup_code);
            byte_out(1'b1, safe);
        end
    endtask
endmodule

// File: sim/tb.sv
/* bench for the layer overlay compositor: table of setups and pixels,
   then hand-written awkward cases. assumes the host model beside it. */
`timescale 1ns/10ps
module tb import overlay_pkg::*; ;
    // ==========================================================
    // signals
    // ==========================================================
    logic        clk, rst_n, pix_valid, cursor_move;        // bench driven
    logic        reg_wr, reg_rd, cmd_wr, par_wr;            // host driven
    logic        layer_setup_busy, three_layers, block1_text, block3_text;
    logic        panel_valid, panel_text;                   // pixel outputs
    logic [1:0]  pix_block;                                 // screen block
    logic [3:0]  glyph_width;                               // glyph field
    logic [7:0]  reg_addr, reg_wdata, bus_data, reg_rdata;  // register port
    logic [7:0]  first_layer, second_layer, third_layer;    // layer bytes
    logic [7:0]  panel_data, rd;                            // results
    logic [15:0] cursor_addr, cursor_step, next_cursor;     // cursor adder
    int          num_errors, check_count, cycles;           // bookkeeping

    typedef struct packed {
        logic [7:0] cfg;   // setup byte
        logic [1:0] blk;   // screen block of the byte
        logic [7:0] data;  // composed byte expected
        logic       txt;   // text flag expected
    } row_t;
    // layers are cc, aa, f0 in every row
    row_t rows [14] = '{
        '{8'h00, 2'd0, 8'hee, 1'b1}, '{8'h04, 2'd0, 8'hee, 1'b0},
        '{8'h08, 2'd0, 8'hee, 1'b1}, '{8'h08, 2'd2, 8'hee, 1'b0},
        '{8'h00, 2'd2, 8'hee, 1'b1}, '{8'h00, 2'd1, 8'hee, 1'b0},
        '{8'h00, 2'd3, 8'hee, 1'b0}, '{8'h01, 2'd0, 8'h66, 1'b1},
        '{8'h02, 2'd2, 8'h88, 1'b1}, '{8'h03, 2'd0, 8'h00, 1'b1},
        '{8'h1c, 2'd0, 8'hfe, 1'b0}, '{8'h1d, 2'd1, 8'hf6, 1'b0},
        '{8'h1e, 2'd2, 8'hf8, 1'b0}, '{8'h1f, 2'd3, 8'h00, 1'b0}};

    // ==========================================================
    // design and host
    // ==========================================================
    layer_overlay_compositor u_dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .cmd_wr(cmd_wr),
        .par_wr(par_wr), .bus_data(bus_data), .pix_valid(pix_valid),
        .pix_block(pix_block), .first_layer(first_layer), .second_layer(second_layer),
        .third_layer(third_layer), .glyph_width(glyph_width), .cursor_addr(cursor_addr),
        .cursor_step(cursor_step), .cursor_move(cursor_move), .reg_rdata(reg_rdata),
        .layer_setup_busy(layer_setup_busy), .three_layers(three_layers),
        .block1_text(block1_text), .block3_text(block3_text), .panel_data(panel_data),
        .panel_valid(panel_valid), .panel_text(panel_text), .next_cursor(next_cursor));
    host_model u_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .cmd_wr(cmd_wr),
        .par_wr(par_wr), .bus_data(bus_data), .reg_rdata(reg_rdata));

    // ==========================================================
    // clock, timeout, helpers
    // ==========================================================
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // the whole run needs well under 600 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            num_errors++;
            conclude();
        end
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one pixel byte, answer due exactly one edge later
    task automatic pix(input logic [1:0] blk, input logic [7:0] exp, input logic txt);
        @(negedge clk);
        pix_valid = 1'b1;
        pix_block = blk;
        @(negedge clk);
        pix_valid = 1'b0;
        chk("panel_valid", 16'(1'b1), 16'(panel_valid));
        chk("panel_data", 16'(exp), 16'(panel_data));
        chk("panel_text", 16'(txt), 16'(panel_text));
        @(negedge clk);
        chk("panel_valid", 16'(1'b0), 16'(panel_valid));
    endtask

    task automatic conclude;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        {num_errors, check_count, cycles} = '0;
        {rst_n, pix_valid, cursor_move, pix_block} = 5'h0;
        {first_layer, second_layer, third_layer} = {8'hcc, 8'haa, 8'hf0};
        glyph_width = 4'h9;
        {cursor_addr, cursor_step} = 32'h0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        // table: odd rows go direct, even rows by the indirect command
        for (int i = 0; i < 14; i++) begin
            u_host.set_cfg(i[0], rows[i].cfg);
            @(negedge clk);
            chk("three_layers", 16'(rows[i].cfg[4]), 16'(three_layers));
            chk("block1_text", 16'(!rows[i].cfg[2]), 16'(block1_text));
            chk("block3_text", 16'(!rows[i].cfg[3]), 16'(block3_text));
            u_host.rd_reg(cfg_offset, rd);
            chk("config", 16'(rows[i].cfg), 16'(rd));
            pix(rows[i].blk, rows[i].data, rows[i].txt);
        end
        $display("test table done");
        // unused bits read as zero, unmapped place ignored and reads zero
        u_host.wr_reg(cfg_offset, 8'hff);
        u_host.wr_reg(8'h19, 8'h00);
        u_host.rd_reg(cfg_offset, rd);
        chk("config", 16'(8'h1f), 16'(rd));
        u_host.rd_reg(8'h19, rd);
        chk("unmapped", 16'(8'h00), 16'(rd));
        $display("test register map done");
        // stray parameter, then a command cancelled by another command
        u_host.byte_out(1'b1, 8'h00);
        u_host.byte_out(1'b0, layer_setup_code);
        chk("busy", 16'(1'b1), 16'(layer_setup_busy));
        u_host.byte_out(1'b0, 8'h00);
        u_host.byte_out(1'b1, 8'h04);
        u_host.rd_reg(cfg_offset, rd);
        chk("config", 16'(8'h1f), 16'(rd));
        u_host.set_cfg(1'b0, 8'h06);
        chk("busy", 16'(1'b0), 16'(layer_setup_busy));
        u_host.rd_reg(cfg_offset, rd);
        chk("config", 16'(8'h06), 16'(rd));
        $display("test indirect done");
        // back to back bytes of one layer in blocks 1 and 3 share a method
        @(negedge clk);
        pix_valid = 1'b1;
        pix_block = 2'd0;
        @(negedge clk);
        pix_block = 2'd2;
        chk("panel_data", 16'(8'h88), 16'(panel_data));
        chk("panel_text", 16'(1'b0), 16'(panel_text));
        @(negedge clk);
        pix_valid = 1'b0;
        chk("panel_data", 16'(8'h88), 16'(panel_data));
        chk("panel_text", 16'(1'b1), 16'(panel_text));
        $display("test block split done");
        // cursor steps by address even with wide glyphs; host presets step
        cursor_addr = 16'hfffe;
        cursor_step = 16'h0009;
        cursor_move = 1'b1;
        @(negedge clk);
        cursor_move = 1'b0;
        chk("next_cursor", 16'h0007, next_cursor);
        $display("test cursor done");
        // reset in mid command wait with a non-zero setup
        u_host.byte_out(1'b0, layer_setup_code);
        rst_n = 1'b0;
        repeat (4) @(negedge clk);
        chk("busy", 16'(1'b0), 16'(layer_setup_busy));
        chk("three_layers", 16'(1'b0), 16'(three_layers));
        chk("block_text", 16'(2'b11), 16'({block1_text, block3_text}));
        rst_n = 1'b1;
        u_host.rd_reg(cfg_offset, rd);
        chk("config", 16'(cfg_reset), 16'(rd));
        $display("test reset done");
        conclude();
    end
endmodule
